//--- src/ctomux_i2c_slave.sv
// Write-only I2C slave holding the expander output port byte
`timescale 1ns/1ps
`default_nettype none
module ctomux_i2c_slave
	import ctomux_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_oe,
	output logic [7:0]      port_reg
);
	typedef enum {ctomux_idle_t, ctomux_addr_t, ctomux_cmd_t, ctomux_data_t,
		ctomux_ack_t, ctomux_skip_t} ctomux_st_t;

	ctomux_st_t  state_reg;
	ctomux_st_t  after_ack_reg;
	logic        scl_d_reg;
	logic        sda_d_reg;
	logic [7:0]  shift_reg;
	logic [3:0]  count_reg;
	logic [7:0]  cmd_reg;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_c;
	logic        stop_c;

	// Inputs are synchronous to core_clk; edges seen by a one-cycle delay
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end
		else
		begin
			scl_d_reg <= scl_in;
			sda_d_reg <= sda_in;
		end
	end

	assign scl_rise = scl_in && !scl_d_reg;
	assign scl_fall = !scl_in && scl_d_reg;
	assign start_c  = scl_in && scl_d_reg && sda_d_reg && !sda_in;
	assign stop_c   = scl_in && scl_d_reg && !sda_d_reg && sda_in;

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			state_reg     <= ctomux_idle_t;
			after_ack_reg <= ctomux_idle_t;
			shift_reg     <= 8'h00;
			count_reg     <= 4'h0;
			cmd_reg       <= 8'h00;
			sda_oe        <= 1'b0;
			port_reg      <= CTOMUX_PORT_RESET;
		end
		else if (start_c)
		begin
			state_reg <= ctomux_addr_t;
			count_reg <= 4'h0;
			sda_oe    <= 1'b0;
		end
		else if (stop_c)
		begin
			state_reg <= ctomux_idle_t;
			sda_oe    <= 1'b0;
		end
		else
		begin
			case (state_reg)
				ctomux_addr_t, ctomux_cmd_t, ctomux_data_t:
				begin
					if (scl_rise)
					begin
						shift_reg <= {shift_reg[6:0], sda_in};
						count_reg <= count_reg + 4'h1;
					end
					else if (scl_fall && count_reg == CTOMUX_BYTE_BITS)
					begin
						count_reg <= 4'h0;
						if (state_reg == ctomux_addr_t)
						begin
							// Only our address with a write bit is acknowledged
							if (shift_reg == {CTOMUX_I2C_ADDR, 1'b0})
							begin
								sda_oe        <= 1'b1;
								state_reg     <= ctomux_ack_t;
								after_ack_reg <= ctomux_cmd_t;
							end
							else
								state_reg <= ctomux_skip_t;
						end
						else if (state_reg == ctomux_cmd_t)
						begin
							cmd_reg       <= shift_reg;
							sda_oe        <= 1'b1;
							state_reg     <= ctomux_ack_t;
							after_ack_reg <= ctomux_data_t;
						end
						else
						begin
							// Port holds until written again; top bit forced low
							if (cmd_reg == CTOMUX_OUTPUT_PORT_CMD)
								port_reg <= shift_reg & CTOMUX_RSVD_MASK;
							sda_oe        <= 1'b1;
							state_reg     <= ctomux_ack_t;
							after_ack_reg <= ctomux_data_t;
						end
					end
				end
				ctomux_ack_t:
				begin
					if (scl_fall)
					begin
						sda_oe    <= 1'b0;
						state_reg <= after_ack_reg;
					end
				end
				default:
				begin
					sda_oe <= 1'b0;
				end
			endcase
		end
	end

	// Acknowledge only after a matching address byte
	addr_ack_a: assert property (@(posedge core_clk) disable iff (reset)
		$rose(sda_oe) && $past(state_reg) == ctomux_addr_t
		|-> $past(shift_reg) == {CTOMUX_I2C_ADDR, 1'b0})
		else $error("ack given to a foreign address");
	rsvd_zero_a: assert property (@(posedge core_clk) disable iff (reset)
		!port_reg[CTOMUX_BIT_RSVD])
		else $error("reserved port bit set");
	port_hold_a: assert property (@(posedge core_clk) disable iff (reset)
		$past(state_reg) != ctomux_data_t |-> $stable(port_reg))
		else $error("port changed outside a data byte");

	// Ack must let go of SDA once the ninth clock falls
	sequence ack_end_s;
		state_reg == ctomux_ack_t && scl_fall;
	endsequence
	ack_release_a: assert property (@(posedge core_clk) disable iff (reset)
		ack_end_s |=> !sda_oe)
		else $error("ack held past the ninth clock");
endmodule : ctomux_i2c_slave
`default_nettype wire

//--- src/ctomux_pkg.sv
// Constants and carrier types for the camera trigger and output mux
package ctomux_pkg;
	localparam logic [6:0] CTOMUX_I2C_ADDR       = 7'h20;
	localparam int         CTOMUX_BIT_PWR        = 0;
	localparam int         CTOMUX_BIT_SRST       = 1;
	localparam int         CTOMUX_BIT_LEVEL      = 2;
	localparam int         CTOMUX_BIT_DRIVE      = 3;
	localparam int         CTOMUX_BIT_FUNC       = 4;
	localparam int         CTOMUX_BIT_TPOL       = 5;
	localparam int         CTOMUX_BIT_TSRC       = 6;
	localparam int         CTOMUX_BIT_RSVD       = 7;
	localparam logic [7:0] CTOMUX_PORT_RESET     = 8'h00;
	localparam logic [7:0] CTOMUX_RSVD_MASK      = 8'h7f;
	localparam logic [7:0] CTOMUX_OUTPUT_PORT_CMD = 8'h01;
	localparam logic [3:0] CTOMUX_BYTE_BITS      = 4'h8;

	typedef struct packed {
		logic out;
		logic oe;
	} ctomux_pin_t;

	typedef struct packed {
		logic sensor_power_enable;
		logic sensor_reset_n;
		logic green_status_lamp;
		logic overcurrent_red_lamp;
		logic sensor_trigger_out;
	} ctomux_ctl_t;
endpackage : ctomux_pkg

//--- src/ctomux_top.sv
// Camera trigger and user output routing behind the I2C expander port
// Contract
// - Port bit 0 switches the sensor supply off at 0 and on at 1.
// - Port bit 1 holds the sensor in reset at 0 and releases it at 1.
// - With function select 0 the level bit only drives the green lamp.
// - With function select 1 a level of 0 pulls the output low, 1 releases or drives it high.
// - Port bit 3 selects open-drain at 0 and push-pull at 1.
// - Port bit 4 routes the sensor strobe at 0 or the level bit at 1 to the output pin.
// - Port bit 5 leaves the connector trigger as is at 0 and inverts it at 1.
// - Port bit 6 forwards the link trigger at 0 or the connector trigger at 1.
// - The expander answers at seven-bit address 0x20 and the host writes there.
// - Strobe and link trigger come in and the selected trigger goes to the sensor.
// - The red lamp lights on output overcurrent while in push-pull mode.
`timescale 1ns/1ps
`default_nettype none
module ctomux_top
	import ctomux_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic        sensor_strobe_in,
	input  wire logic        link_trigger_in,
	input  wire logic        connector_trigger_in,
	input  wire logic        overcurrent_in,
	output ctomux_pin_t      user_output_pin,
	output ctomux_ctl_t      ctl_reg
);
	logic [7:0]  port_reg;
	logic        sensor_power_enable;
	logic        output_function_select;
	logic        drive_type_select;
	logic        user_output_level_bit;
	logic        user_output_line;
	logic        trig_next;
	logic        live_reg;
	ctomux_pin_t pin_next;

	ctomux_i2c_slave u_slave (
		.core_clk (core_clk),
		.reset    (reset),
		.scl_in   (scl_in),
		.sda_in   (sda_in),
		.sda_oe   (sda_oe),
		.port_reg (port_reg)
	);

	// Open-drain ack: the line is only ever pulled low
	assign sda_out = 1'b0;

	assign sensor_power_enable    = port_reg[CTOMUX_BIT_PWR];
	assign user_output_level_bit  = port_reg[CTOMUX_BIT_LEVEL];
	assign drive_type_select      = port_reg[CTOMUX_BIT_DRIVE];
	assign output_function_select = port_reg[CTOMUX_BIT_FUNC];

	always_comb
	begin
		// Link trigger or polarity-adjusted connector trigger
		if (port_reg[CTOMUX_BIT_TSRC])
			trig_next = connector_trigger_in ^ port_reg[CTOMUX_BIT_TPOL];
		else
			trig_next = link_trigger_in;
		// Strobe or software level onto the user line
		user_output_line = output_function_select ? user_output_level_bit
			: sensor_strobe_in;
		// Low always driven; high driven only in push-pull
		pin_next.out = user_output_line;
		pin_next.oe  = !user_output_line || drive_type_select;
	end

	// Outputs registered so pins never glitch on combinational paths
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			ctl_reg         <= '0;
			user_output_pin <= '0;
		end
		else
		begin
			ctl_reg.sensor_power_enable  <= sensor_power_enable;
			ctl_reg.sensor_reset_n       <= port_reg[CTOMUX_BIT_SRST];
			// Lamp follows the level only in lamp mode
			ctl_reg.green_status_lamp    <= !output_function_select && user_output_level_bit;
			ctl_reg.overcurrent_red_lamp <= overcurrent_in && drive_type_select;
			ctl_reg.sensor_trigger_out   <= trig_next;
			user_output_pin              <= pin_next;
		end
	end

	// First edge after reset still shows cleared flops, so the follow checks wait one edge
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			live_reg <= 1'b0;
		else
			live_reg <= 1'b1;
	end

	power_follow_a: assert property (@(posedge core_clk) disable iff (reset)
		live_reg |-> ctl_reg.sensor_power_enable == $past(port_reg[CTOMUX_BIT_PWR]))
		else $error("sensor power does not follow port bit");
	reset_follow_a: assert property (@(posedge core_clk) disable iff (reset)
		live_reg |-> ctl_reg.sensor_reset_n == $past(port_reg[CTOMUX_BIT_SRST]))
		else $error("sensor reset does not follow port bit");
	green_lamp_a: assert property (@(posedge core_clk) disable iff (reset)
		$past(output_function_select) |-> !ctl_reg.green_status_lamp)
		else $error("green lamp lit in output mode");
	drive_low_a: assert property (@(posedge core_clk) disable iff (reset)
		$past(output_function_select) && !$past(user_output_level_bit)
		|-> user_output_pin.oe && !user_output_pin.out)
		else $error("output not pulled low");
	open_drain_a: assert property (@(posedge core_clk) disable iff (reset)
		!$past(drive_type_select) && user_output_pin.oe |-> !user_output_pin.out)
		else $error("open-drain output driven high");
	strobe_route_a: assert property (@(posedge core_clk) disable iff (reset)
		!$past(output_function_select) && $past(drive_type_select)
		|-> user_output_pin.out == $past(sensor_strobe_in))
		else $error("strobe not routed to output");
	trig_route_a: assert property (@(posedge core_clk) disable iff (reset)
		live_reg |-> ctl_reg.sensor_trigger_out == ($past(port_reg[CTOMUX_BIT_TSRC])
		? $past(connector_trigger_in) ^ $past(port_reg[CTOMUX_BIT_TPOL])
		: $past(link_trigger_in)))
		else $error("wrong trigger forwarded");
	red_lamp_a: assert property (@(posedge core_clk) disable iff (reset)
		live_reg |-> ctl_reg.overcurrent_red_lamp == ($past(overcurrent_in)
		&& $past(drive_type_select)))
		else $error("red lamp wrong");
	push_pull_a: assert property (@(posedge core_clk) disable iff (reset)
		live_reg && $past(drive_type_select) |-> user_output_pin.oe)
		else $error("push-pull output not driven");
	od_release_a: assert property (@(posedge core_clk) disable iff (reset)
		live_reg && !$past(drive_type_select) && $past(output_function_select)
		&& $past(user_output_level_bit) |-> !user_output_pin.oe)
		else $error("open-drain high level not released");
	line_route_a: assert property (@(posedge core_clk) disable iff (reset)
		live_reg |-> user_output_pin.out == ($past(output_function_select)
		? $past(user_output_level_bit) : $past(sensor_strobe_in)))
		else $error("wrong source on user output");
endmodule : ctomux_top
`default_nettype wire

//--- tb/ctomux_host.sv
// Behavioural I2C host that writes the expander port
`timescale 1ns/1ps
`default_nettype none
module ctomux_host
	import ctomux_pkg::*;
(
	input  wire logic core_clk,
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda_wire
);
	// SCL rests high between frames, so a stray edge cannot look like a bit
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick
	task automatic start();
		tick(1);
		sda_low <= 1'b1;
		tick(4);
		scl <= 1'b0;
		tick(2);
	endtask : start
	// Eight bits MSB first, then SDA is released for the ninth clock
	task automatic send(input logic [7:0] b, output logic ack);
		for (int i = 8; i >= 0; i--)
		begin
			sda_low <= (i > 0) ? !b[i - 1] : 1'b0;
			tick(2);
			scl <= 1'b1;
			tick(2);
			ack = !sda_wire;
			tick(2);
			scl <= 1'b0;
			tick(2);
		end
	endtask : send
	task automatic stop();
		sda_low <= 1'b1;
		tick(2);
		scl <= 1'b1;
		tick(2);
		sda_low <= 1'b0;
		tick(4);
	endtask : stop
endmodule : ctomux_host
`default_nettype wire

//--- tb/camera_trigger_output_mux_bench.sv
// Self-checking bench for the camera trigger and output mux
`timescale 1ns/1ps
`default_nettype none
module camera_trigger_output_mux_bench
	import ctomux_pkg::*;
();
	logic        core_clk, reset, scl, host_low, sda_wire, sda_oe, sda_drv;
	logic        strobe, link, conn, oc;
	ctomux_pin_t pin;
	ctomux_ctl_t ctl;
	logic [7:0]  pm;
	logic [31:0] rnd;
	int          n_errors, num_checks;
	// Open-drain SDA with pull-up
	assign sda_wire = !host_low && (sda_oe ? sda_drv : 1'b1);
	ctomux_host host (.core_clk(core_clk), .scl(scl), .sda_low(host_low), .sda_wire(sda_wire));
	ctomux_top DUT (.core_clk(core_clk), .reset(reset), .scl_in(scl), .sda_in(sda_wire),
		.sda_out(sda_drv), .sda_oe(sda_oe), .sensor_strobe_in(strobe), .link_trigger_in(link),
		.connector_trigger_in(conn), .overcurrent_in(oc), .user_output_pin(pin), .ctl_reg(ctl));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk(input string what, input logic exp, input logic seen);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %b seen %b", what, exp, seen);
		end
	endtask : chk
	task automatic results();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results
	// Port stays fixed while the live inputs move
	task automatic check_outs();
		logic src;
		repeat (4)
		begin
			@(posedge core_clk);
			rnd = lfsr(rnd);
			{strobe, link, conn, oc} <= rnd[3:0];
			repeat (3) @(posedge core_clk);
			#1;
			src = pm[CTOMUX_BIT_FUNC] ? pm[CTOMUX_BIT_LEVEL] : strobe;
			chk("power", pm[0], ctl.sensor_power_enable);
			chk("reset_n", pm[1], ctl.sensor_reset_n);
			chk("green", pm[2] & !pm[CTOMUX_BIT_FUNC], ctl.green_status_lamp);
			chk("pin_oe", pm[3] | !src, pin.oe);
			if (pin.oe === 1'b1)
				chk("pin_out", pm[3] & src, pin.out);
			chk("red", oc & pm[3], ctl.overcurrent_red_lamp);
			chk("trig", pm[6] ? conn ^ pm[5] : link, ctl.sensor_trigger_out);
		end
	endtask : check_outs
	// A read-flagged address is refused; a second data byte rewrites the port
	task automatic wr(input logic [6:0] a, input logic rd, input logic [7:0] c,
		input logic [7:0] d, input logic [7:0] d2, input logic two);
		logic ack;
		logic ok;
		ok = (a == CTOMUX_I2C_ADDR) && !rd;
		host.start();
		host.send({a, rd}, ack);
		chk("ack_addr", ok, ack);
		host.send(c, ack);
		chk("ack_cmd", ok, ack);
		host.send(d, ack);
		chk("ack_data", ok, ack);
		if (ok && c == CTOMUX_OUTPUT_PORT_CMD)
			pm = d & CTOMUX_RSVD_MASK;
		if (two)
		begin
			host.send(d2, ack);
			chk("ack_data2", ok, ack);
			if (ok && c == CTOMUX_OUTPUT_PORT_CMD)
				pm = d2 & CTOMUX_RSVD_MASK;
		end
		host.stop();
	endtask : wr
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = !core_clk;
	end
	initial
	begin
		reset = 1'b1;
		{strobe, link, conn, oc} = 4'h0;
		rnd = 32'h2a4c4415;
		pm = 8'h00;
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		check_outs();
		// Every fifth write goes to a random address, every sixth a random command,
		// some carry the read flag and some a second data byte
		for (int i = 0; i < 40; i++)
		begin
			rnd = lfsr(rnd);
			wr((i % 5 == 4) ? rnd[14:8] : CTOMUX_I2C_ADDR, i % 7 == 3,
				(i % 6 == 5) ? rnd[23:16] : CTOMUX_OUTPUT_PORT_CMD,
				rnd[7:0], rnd[31:24], i % 4 == 1);
			check_outs();
		end
		// Reset in mid-run must clear the port, every control output and the pin enable
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (5) @(posedge core_clk);
		#1;
		chk("rst_ctl", 1'b0, |ctl);
		chk("rst_oe", 1'b0, pin.oe);
		@(posedge core_clk);
		reset <= 1'b0;
		pm = 8'h00;
		check_outs();
		rnd = lfsr(rnd);
		wr(CTOMUX_I2C_ADDR, 1'b0, CTOMUX_OUTPUT_PORT_CMD, rnd[7:0], rnd[31:24], 1'b1);
		check_outs();
		results();
	end
	initial
	begin
		repeat (100000) @(posedge core_clk);
		n_errors++;
		results();
	end
endmodule : camera_trigger_output_mux_bench
`default_nettype wire
